//--- core/gpodc_pin_drv.sv
`timescale 1ns/1ns
module gpodc_pin_drv #(
	parameter int N = 19
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Per-pin configuration
	input  wire logic [N-1:0] level,
	input  wire logic [N-1:0] open_drain,
	input  wire logic [N-1:0] is_output,
	// Pin side
	output logic      [N-1:0] pin_o,
	output logic      [N-1:0] pin_oe_n
);
	logic [N-1:0] o_d;
	logic [N-1:0] oe_n_d;
	// Per-pin drive decision
	always_comb begin
		for (int i = 0; i < N; i++) begin
			o_d[i]    = open_drain[i] ? 1'b0 : level[i];
			oe_n_d[i] = !(is_output[i] && !(open_drain[i] && level[i]));
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_o    <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_o    <= o_d;
			pin_oe_n <= oe_n_d;
		end
	end
	inputs_float_a: assert property (@(posedge clk) disable iff (rst)
		!$past(is_output[0]) |-> pin_oe_n[0])
		else $error("input pin driven");
	od_no_high_a: assert property (@(posedge clk) disable iff (rst)
		!pin_oe_n[0] && $past(open_drain[0]) |-> !pin_o[0])
		else $error("open drain drove high");
endmodule

//--- core/gpodc_top.sv
`timescale 1ns/1ns
`include "gpodc_map.svh"
// What this block does
// - Register 0x2A holds output levels of pins 8..1 in bits 7..0, 1 high and 0 low.
// - Register 0x2B holds readable output levels of pins 16..9 in bits 7..0, 1 high and 0 low.
// - Register 0x2C holds output levels of pins 17..19 in bits 0..2, bits 7..3 reserved.
// - Registers 0x2D and 0x2E hold drive type of pins 1..8 and 9..16, 0 push-pull, 1 open drain.
// - Register 0x2F holds drive type of pins 17..19 in bits 0..2, bits 7..3 reserved.
// - Register 0x30 holds direction of pins 8..1, 1 output and 0 input.
// - Register 0x31 holds direction of pins 16..9, 1 output and 0 input.
// - Register 0x32 holds direction of pins 17..19 in bits 0..2, bits 7..3 reserved.
module gpodc_top
	import gpodc_pkg::*;
(
	// Clock and reset
	input  wire logic                       SYS_CLK,
	input  wire logic                       RST,
	// Register port
	input  wire logic [`GPODC_ADDR_W-1:0]   REG_ADDR,
	input  wire logic                       REG_WR,
	input  wire gpodc_pkg::gpodc_byte_t     REG_WDATA,
	input  wire logic                       REG_RD,
	output gpodc_pkg::gpodc_byte_t          REG_RDATA,
	output logic                            REG_RVALID,
	// Pins
	output logic [`GPODC_PINS-1:0]          PIN_O,
	output logic [`GPODC_PINS-1:0]          PIN_OE_N
);
	import gpodc_pkg::*;
	localparam int N = `GPODC_PINS;
	localparam int U = `GPODC_UP_BITS;

	logic [N-1:0] level_q, level_d;
	logic [N-1:0] drv_q, drv_d;
	logic [N-1:0] dir_q, dir_d;
	gpodc_byte_t  rdata_q, rdata_d;
	logic         rvalid_q, rvalid_d;

	// Register writes and reads
	always_comb begin
		level_d  = level_q;
		drv_d    = drv_q;
		dir_d    = dir_q;
		rdata_d  = rdata_q;
		rvalid_d = REG_RD;
		if (REG_WR) begin
			unique case (REG_ADDR)
				`GPODC_OFS_LVL_LO:  level_d[7:0]    = REG_WDATA;
				`GPODC_OFS_LVL_MID: level_d[15:8]   = REG_WDATA;
				`GPODC_OFS_LVL_UP:  level_d[N-1:16] = REG_WDATA[U-1:0];
				`GPODC_OFS_DRV_LO:  drv_d[7:0]      = REG_WDATA;
				`GPODC_OFS_DRV_MID: drv_d[15:8]     = REG_WDATA;
				`GPODC_OFS_DRV_UP:  drv_d[N-1:16]   = REG_WDATA[U-1:0];
				`GPODC_OFS_DIR_LO:  dir_d[7:0]      = REG_WDATA;
				`GPODC_OFS_DIR_MID: dir_d[15:8]     = REG_WDATA;
				`GPODC_OFS_DIR_UP:  dir_d[N-1:16]   = REG_WDATA[U-1:0];
				default: ;
			endcase
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				`GPODC_OFS_LVL_LO:  rdata_d = level_q[7:0];
				`GPODC_OFS_LVL_MID: rdata_d = level_q[15:8];
				`GPODC_OFS_LVL_UP:  rdata_d = {5'h0, level_q[N-1:16]};
				`GPODC_OFS_DRV_LO:  rdata_d = drv_q[7:0];
				`GPODC_OFS_DRV_MID: rdata_d = drv_q[15:8];
				`GPODC_OFS_DRV_UP:  rdata_d = {5'h0, drv_q[N-1:16]};
				`GPODC_OFS_DIR_LO:  rdata_d = dir_q[7:0];
				`GPODC_OFS_DIR_MID: rdata_d = dir_q[15:8];
				`GPODC_OFS_DIR_UP:  rdata_d = {5'h0, dir_q[N-1:16]};
				default:            rdata_d = `GPODC_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			level_q  <= '0;
			drv_q    <= '0;
			dir_q    <= '0;
			rdata_q  <= `GPODC_RST_BYTE;
			rvalid_q <= 1'b0;
		end else begin
			level_q  <= level_d;
			drv_q    <= drv_d;
			dir_q    <= dir_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign REG_RDATA  = rdata_q;
	assign REG_RVALID = rvalid_q;

	// Pin stage
	gpodc_pin_drv #(.N(N)) u_drv (
		.clk        (SYS_CLK),
		.rst        (RST),
		.level      (level_q),
		.open_drain (drv_q),
		.is_output  (dir_q),
		.pin_o      (PIN_O),
		.pin_oe_n   (PIN_OE_N)
	);

	// Write, idle cycle, then read of one register
	sequence wr_lvl_mid_s;
		REG_WR && REG_ADDR == `GPODC_OFS_LVL_MID;
	endsequence
	sequence rd_lvl_mid_s;
		REG_RD && REG_ADDR == `GPODC_OFS_LVL_MID;
	endsequence
	sequence wr_gap_rd_s;
		wr_lvl_mid_s ##1 !REG_WR ##1 (rd_lvl_mid_s and !REG_WR);
	endsequence
	lvl_mid_back_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		wr_gap_rd_s |=> REG_RDATA == $past(REG_WDATA, 3))
		else $error("level mid readback wrong");

	// Writes land in their bank
	lvl_lo_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_LVL_LO |=> level_q[7:0] == $past(REG_WDATA))
		else $error("level low not stored");
	lvl_mid_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_LVL_MID |=> level_q[15:8] == $past(REG_WDATA))
		else $error("level mid not stored");
	lvl_up_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_LVL_UP |=> level_q[N-1:16] == $past(REG_WDATA[U-1:0]))
		else $error("level upper not stored");
	drv_lo_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_DRV_LO |=> drv_q[7:0] == $past(REG_WDATA))
		else $error("drive low not stored");
	drv_mid_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_DRV_MID |=> drv_q[15:8] == $past(REG_WDATA))
		else $error("drive mid not stored");
	drv_up_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_DRV_UP |=> drv_q[N-1:16] == $past(REG_WDATA[U-1:0]))
		else $error("drive upper not stored");
	dir_lo_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_DIR_LO |=> dir_q[7:0] == $past(REG_WDATA))
		else $error("direction low not stored");
	dir_mid_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_DIR_MID |=> dir_q[15:8] == $past(REG_WDATA))
		else $error("direction mid not stored");
	dir_up_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_WR && REG_ADDR == `GPODC_OFS_DIR_UP |=> dir_q[N-1:16] == $past(REG_WDATA[U-1:0]))
		else $error("direction upper not stored");

	// Reads return the stored bank
	rd_lvl_lo_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_LVL_LO |=> REG_RDATA == $past(level_q[7:0]))
		else $error("level low read wrong");
	rd_lvl_mid_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_LVL_MID |=> REG_RDATA == $past(level_q[15:8]))
		else $error("level mid read wrong");
	rd_lvl_up_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_LVL_UP |=> REG_RDATA[U-1:0] == $past(level_q[N-1:16]))
		else $error("level upper read wrong");
	rd_drv_lo_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_DRV_LO |=> REG_RDATA == $past(drv_q[7:0]))
		else $error("drive low read wrong");
	rd_drv_mid_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_DRV_MID |=> REG_RDATA == $past(drv_q[15:8]))
		else $error("drive mid read wrong");
	rd_drv_up_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_DRV_UP |=> REG_RDATA[U-1:0] == $past(drv_q[N-1:16]))
		else $error("drive upper read wrong");
	rd_dir_lo_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_DIR_LO |=> REG_RDATA == $past(dir_q[7:0]))
		else $error("direction low read wrong");
	rd_dir_mid_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_DIR_MID |=> REG_RDATA == $past(dir_q[15:8]))
		else $error("direction mid read wrong");
	rd_dir_up_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_DIR_UP |=> REG_RDATA[U-1:0] == $past(dir_q[N-1:16]))
		else $error("direction upper read wrong");

	// Reserved bits read as zero
	lvl_up_resv_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_LVL_UP |=> REG_RDATA[7:3] == 5'h0)
		else $error("reserved bits nonzero");
	drv_up_resv_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_DRV_UP |=> REG_RDATA[7:3] == 5'h0)
		else $error("drive reserved bits nonzero");
	dir_up_resv_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD && REG_ADDR == `GPODC_OFS_DIR_UP |=> REG_RDATA[7:3] == 5'h0)
		else $error("direction reserved bits nonzero");

	// Read answer timing
	rvalid_pulse_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		REG_RD |=> REG_RVALID)
		else $error("read not answered");
	rvalid_idle_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!REG_RD |=> !REG_RVALID)
		else $error("answer without read");
	rdata_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without read");

	// Banks hold without a write
	lvl_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!REG_WR |=> $stable(level_q))
		else $error("level changed without write");
	drv_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!REG_WR |=> $stable(drv_q))
		else $error("drive type changed without write");
	dir_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!REG_WR |=> $stable(dir_q))
		else $error("direction changed without write");

	// Pin drive per mode
	pp_drive_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		dir_q[8] && !drv_q[8] |=> !PIN_OE_N[8] && PIN_O[8] == $past(level_q[8]))
		else $error("push-pull pin wrong");
	od_low_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		dir_q[N-1] && drv_q[N-1] && !level_q[N-1] |=> !PIN_OE_N[N-1] && !PIN_O[N-1])
		else $error("open drain low not pulled");
	od_release_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		dir_q[N-1] && drv_q[N-1] && level_q[N-1] |=> PIN_OE_N[N-1])
		else $error("open drain high not released");
	input_release_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!dir_q[N-1] |=> PIN_OE_N[N-1])
		else $error("input pin driven");
endmodule

//--- shared/gpodc_map.svh
`ifndef GPODC_MAP_SVH
`define GPODC_MAP_SVH
`define GPODC_ADDR_W      8
`define GPODC_PINS        19
`define GPODC_OFS_LVL_LO  8'h2A
`define GPODC_OFS_LVL_MID 8'h2B
`define GPODC_OFS_LVL_UP  8'h2C
`define GPODC_OFS_DRV_LO  8'h2D
`define GPODC_OFS_DRV_MID 8'h2E
`define GPODC_OFS_DRV_UP  8'h2F
`define GPODC_OFS_DIR_LO  8'h30
`define GPODC_OFS_DIR_MID 8'h31
`define GPODC_OFS_DIR_UP  8'h32
`define GPODC_RST_BYTE    8'h00
`define GPODC_UP_BITS     3
`endif

//--- shared/gpodc_pkg.sv
package gpodc_pkg;
	typedef logic [7:0] gpodc_byte_t;
	typedef enum logic [1:0] {GPODC_LO, GPODC_MID, GPODC_UP} gpodc_bank_t;
endpackage

//--- sim/gpodc_host.sv
`timescale 1ns/1ns
module gpodc_host
	import gpodc_pkg::*;
(
	// Clock
	input  wire logic                   clk,
	// Register port
	output logic [7:0]                  addr,
	output logic                        wr,
	output gpodc_pkg::gpodc_byte_t      wdata,
	output logic                        rd,
	input  wire gpodc_pkg::gpodc_byte_t rdata,
	input  wire logic                   rvalid
);
	import gpodc_pkg::*;
	initial begin
		addr = 8'h00;
		wr = 1'b0;
		wdata = 8'h00;
		rd = 1'b0;
	end
	// One-cycle write strobe
	task automatic write_reg(input logic [7:0] a, input gpodc_byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read strobe, answer taken one cycle later
	task automatic read_reg(input logic [7:0] a, output gpodc_byte_t d, output logic v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
		v = rvalid;
	endtask
endmodule

//--- sim/test_gpio_output_direction_ctrl.sv
`timescale 1ns/1ns
module test_gpio_output_direction_ctrl;
	import gpodc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr;
	logic wr, rd, rvalid;
	gpodc_byte_t wdata, rdata;
	logic [18:0] pin_o, pin_oe_n;
	gpodc_byte_t reg_m [0:8];
	int bad_count = 0;
	int checks = 0;
	int cycles = 0;
	always #4 sys_clk = ~sys_clk;
	gpodc_top gpodc_top_i (.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
		.REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .PIN_O(pin_o), .PIN_OE_N(pin_oe_n));
	gpodc_host gpodc_host_i (.clk(sys_clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata),
		.rvalid(rvalid));
	task automatic end_sim;
		if (bad_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Read every place around the map and compare pins with the model
	task automatic check_all;
		gpodc_byte_t d;
		logic v;
		logic [18:0] lvl, od, dir, oe_n;
		for (int a = 8'h29; a <= 8'h33; a++) begin
			gpodc_host_i.read_reg(8'(a), d, v);
			chk(19'(v), 19'h1);
			chk(19'(d), (a >= 8'h2A && a <= 8'h32) ? 19'(reg_m[a - 8'h2A]) : 19'h0);
		end
		lvl = {reg_m[2][2:0], reg_m[1], reg_m[0]};
		od = {reg_m[5][2:0], reg_m[4], reg_m[3]};
		dir = {reg_m[8][2:0], reg_m[7], reg_m[6]};
		oe_n = ~dir | (od & lvl);
		chk(pin_oe_n, oe_n);
		chk(pin_o & ~oe_n, dir & ~od & lvl);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 8000) begin
			bad_count++;
			end_sim();
		end
	end
	initial begin
		logic [7:0] a;
		gpodc_byte_t d;
		gpodc_byte_t rb;
		logic rv;
		void'($urandom(32'hde18_0ade));
		for (int i = 0; i < 9; i++) begin
			reg_m[i] = 8'h00;
		end
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		check_all();
		for (int n = 0; n < 60; n++) begin
			a = 8'(8'h29 + $urandom_range(0, 10));
			d = 8'($urandom);
			gpodc_host_i.write_reg(a, d);
			if (a >= 8'h2A && a <= 8'h32) begin
				reg_m[a - 8'h2A] = ((a - 8'h2A) % 3 == 2) ? (d & 8'h07) : d;
			end
			gpodc_host_i.read_reg(a, rb, rv);
			chk(19'(rv), 19'h1);
			chk(19'(rb), (a >= 8'h2A && a <= 8'h32) ? 19'(reg_m[a - 8'h2A]) : 19'h0);
			if (n % 4 == 3) begin
				check_all();
			end
		end
		check_all();
		end_sim();
	end
endmodule
